// File: hdl/slsi_pkg.sv
// Package for the lane status and link interrupt enable block.
// Assumes one register clock; the link page selector is kept in this block.
package slsi_pkg;

  // Number of links selectable by the page register
  localparam int NUM_LINKS  = 2;
  // Alignment configuration bytes per link, checksum last
  localparam int ILAS_BYTES = 14;
  localparam logic [3:0] ILAS_LAST_IDX = 4'hd;

  // Register offsets
  localparam logic [11:0] LINK_PAGE_ADDR    = 12'h300;
  localparam logic [11:0] ILAS_PROG_FIRST   = 12'h450;
  localparam logic [11:0] ILAS_PROG_LAST    = 12'h45d;
  localparam logic [11:0] LANE7_STATUS_ADDR = 12'h4b7;
  localparam logic [11:0] IRQ_ENABLE_A_ADDR = 12'h4b8;
  localparam logic [11:0] IRQ_ENABLE_B_ADDR = 12'h4b9;
  localparam logic [11:0] IRQ_STATUS_A_ADDR = 12'h4ba;
  localparam logic [11:0] IRQ_STATUS_B_ADDR = 12'h4bb;

  // Field positions, shared by enable A, status A and the lane flags; the last two are for enable/status B and the page
  localparam int BIT_BAD_DISPARITY = 7;
  localparam int BIT_NOT_IN_TABLE  = 6;
  localparam int BIT_UNEXP_CTRL    = 5;
  localparam int BIT_DESKEW        = 4;
  localparam int BIT_INITIAL_SYNC  = 3;
  localparam int BIT_CHECKSUM      = 2;
  localparam int BIT_FRAME_SYNC    = 1;
  localparam int BIT_CODE_GROUP    = 0;
  localparam int BIT_CONFIG_MISM   = 0;
  localparam int BIT_LINK_PAGE     = 0;

  // Reset values
  localparam logic [7:0] LANE7_STATUS_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_A_RESET = 8'h00;
  localparam logic       IRQ_ENABLE_B_RESET = 1'b0;
  localparam logic [7:0] IRQ_STATUS_A_RESET = 8'h00;
  localparam logic       IRQ_STATUS_B_RESET = 1'b0;
  localparam logic       LINK_PAGE_RESET    = 1'b0;
  localparam logic [7:0] ILAS_PROG_RESET    = 8'h00;

  // Register port request, one cycle per strobe
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } slsi_bus_req_type;

  // Per-link flags from the receive side, same order as status A
  typedef struct packed {
    logic bad_disparity;
    logic not_in_table;
    logic unexp_ctrl;
    logic deskew;
    logic initial_sync;
    logic checksum_ok;
    logic frame_sync;
    logic code_group_sync;
  } slsi_lane_flags_type;

  // One received alignment configuration byte of lane 0
  typedef struct packed {
    logic       valid;
    logic       link;
    logic [3:0] idx;
    logic [7:0] data;
  } slsi_ilas_byte_type;

  typedef logic [ILAS_BYTES-1:0][7:0] slsi_ilas_set_type;

endpackage

// File: hdl/slsi_sync.sv
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit changes slowly relative to clk; no word coherence.
module slsi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);
  import slsi_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } slsi_sync_state_type;

  slsi_sync_state_type state_reg;
  slsi_sync_state_type state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = d_async;
    state_next.stable = state_reg.meta;
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.stable;
endmodule

// File: hdl/slsi_ilas_check.sv
// Checks one link's received alignment configuration on lane 0.
// Assumes bytes arrive in index order 0..13 on the register clock.
module slsi_ilas_check (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire slsi_pkg::slsi_ilas_byte_type byte_in,
  input  wire slsi_pkg::slsi_ilas_set_type  prog,
  output logic                             mismatch_pulse,
  output logic                             cks_bad_pulse
);
  import slsi_pkg::*;

  typedef struct packed {
    logic [7:0] sum;
    logic       differs;
    logic       mismatch;
    logic       cks_bad;
  } slsi_check_state_type;

  slsi_check_state_type state_reg;
  slsi_check_state_type state_next;
  logic [7:0]           sum_base;
  logic                 differs_base;
  logic                 byte_differs;

  // Accumulate the checksum and the comparison; report on the last byte
  always_comb begin
    state_next          = state_reg;
    state_next.mismatch = 1'b0;
    state_next.cks_bad  = 1'b0;
    sum_base            = (byte_in.idx == 4'h0) ? 8'h00 : state_reg.sum;
    differs_base        = (byte_in.idx == 4'h0) ? 1'b0 : state_reg.differs;
    byte_differs        = (byte_in.data != prog[byte_in.idx]);
    if (byte_in.valid) begin
      if (byte_in.idx == ILAS_LAST_IDX) begin
        // Checksum uses received bytes only, never the programmed one
        state_next.cks_bad  = (sum_base != byte_in.data);
        state_next.mismatch = differs_base | byte_differs;
        state_next.differs  = 1'b0;
        state_next.sum      = 8'h00;
      end else begin
        state_next.sum     = 8'(sum_base + byte_in.data);
        state_next.differs = differs_base | byte_differs;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mismatch_pulse = state_reg.mismatch;
  assign cks_bad_pulse  = state_reg.cks_bad;
endmodule

// File: hdl/slsi_irq_ctrl.sv
// Lane 7 status flags and link interrupt enables, status and request.
// Assumes lane flags come from another clock domain and the alignment
// byte stream comes from logic on clk.
module slsi_irq_ctrl (
  input  wire logic                                                   clk,
  input  wire logic                                                   reset,
  input  wire slsi_pkg::slsi_bus_req_type                              bus_req,
  output logic      [7:0]                                             rd_data,
  input  wire slsi_pkg::slsi_lane_flags_type [slsi_pkg::NUM_LINKS-1:0] lane_flags_async,
  input  wire slsi_pkg::slsi_ilas_byte_type                            ilas_byte,
  output logic                                                        irq
);
  import slsi_pkg::*;

  typedef struct packed {
    logic                                link_page;
    logic [NUM_LINKS-1:0][7:0]           en_a;
    logic [NUM_LINKS-1:0]                en_b;
    logic [NUM_LINKS-1:0][7:0]           st_a;
    logic [NUM_LINKS-1:0]                st_b;
    logic [NUM_LINKS-1:0][ILAS_BYTES-1:0][7:0] prog;
    logic [NUM_LINKS-1:0][7:0]           prev;
    logic [7:0]                          rdata;
  } slsi_ctrl_state_type;

  slsi_ctrl_state_type       state_reg;
  slsi_ctrl_state_type       state_next;
  logic [NUM_LINKS*8-1:0]    flags_bits;
  logic [NUM_LINKS-1:0][7:0] flags;
  logic [NUM_LINKS-1:0][7:0] rise;
  logic [NUM_LINKS-1:0][7:0] fall;
  logic [NUM_LINKS-1:0][7:0] set_a;
  logic [NUM_LINKS-1:0]      set_b;
  logic [NUM_LINKS-1:0]      mism_pulse;
  logic [NUM_LINKS-1:0]      cks_bad_pulse;
  logic [7:0]                clr_a;
  logic                      clr_b;
  logic                      pg;

  // Address falls in the programmed configuration byte range
  function automatic logic is_prog(input logic [11:0] a);
    return (a >= ILAS_PROG_FIRST) && (a <= ILAS_PROG_LAST);
  endfunction

  // Byte index of a programmed configuration address
  function automatic logic [3:0] prog_idx(input logic [11:0] a);
    return 4'(a - ILAS_PROG_FIRST);
  endfunction

  // Bring the receive-side flags onto clk
  slsi_sync #(
    .W (NUM_LINKS * 8)
  ) u_flag_sync (
    .clk     (clk),
    .reset   (reset),
    .d_async (lane_flags_async),
    .q       (flags_bits)
  );

  assign flags = flags_bits;

  // One configuration checker per link, fed by its own lane 0 stream
  generate
    for (genvar i = 0; i < NUM_LINKS; i++) begin : g_check
      slsi_ilas_byte_type link_byte;

      always_comb begin
        link_byte       = ilas_byte;
        link_byte.valid = ilas_byte.valid && (ilas_byte.link == 1'(i));
      end

      slsi_ilas_check u_check (
        .clk            (clk),
        .reset          (reset),
        .byte_in        (link_byte),
        .prog           (state_reg.prog[i]),
        .mismatch_pulse (mism_pulse[i]),
        .cks_bad_pulse  (cks_bad_pulse[i])
      );
    end
  endgenerate

  // Event detection: counters and deskew on rise, sync losses on fall
  always_comb begin
    for (int i = 0; i < NUM_LINKS; i++) begin
      rise[i]  = flags[i] & ~state_reg.prev[i];
      fall[i]  = ~flags[i] & state_reg.prev[i];
      set_a[i] = 8'h00;
      set_a[i][BIT_BAD_DISPARITY] = rise[i][BIT_BAD_DISPARITY];
      set_a[i][BIT_NOT_IN_TABLE]  = rise[i][BIT_NOT_IN_TABLE];
      set_a[i][BIT_UNEXP_CTRL]    = rise[i][BIT_UNEXP_CTRL];
      set_a[i][BIT_DESKEW]        = rise[i][BIT_DESKEW];
      set_a[i][BIT_INITIAL_SYNC]  = fall[i][BIT_INITIAL_SYNC];
      set_a[i][BIT_CHECKSUM]      = cks_bad_pulse[i];
      set_a[i][BIT_FRAME_SYNC]    = fall[i][BIT_FRAME_SYNC];
      set_a[i][BIT_CODE_GROUP]    = fall[i][BIT_CODE_GROUP];
      set_b[i] = mism_pulse[i];
    end
  end

  // Write-one-to-clear masks for the selected link
  always_comb begin
    pg    = state_reg.link_page;
    clr_a = 8'h00;
    clr_b = 1'b0;
    if (bus_req.wr && (bus_req.addr == IRQ_STATUS_A_ADDR)) begin
      clr_a = bus_req.wdata;
    end
    if (bus_req.wr && (bus_req.addr == IRQ_STATUS_B_ADDR)) begin
      clr_b = bus_req.wdata[BIT_CONFIG_MISM];
    end
  end

  // Next state: register writes, sticky status, read data
  always_comb begin
    state_next       = state_reg;
    state_next.rdata = 8'h00;
    state_next.prev  = flags;

    // Sticky status; a new event beats a clear in the same cycle
    for (int i = 0; i < NUM_LINKS; i++) begin
      if (pg == 1'(i)) begin
        state_next.st_a[i] = (state_reg.st_a[i] & ~clr_a) | set_a[i];
        state_next.st_b[i] = (state_reg.st_b[i] & ~clr_b) | set_b[i];
      end else begin
        state_next.st_a[i] = state_reg.st_a[i] | set_a[i];
        state_next.st_b[i] = state_reg.st_b[i] | set_b[i];
      end
    end

    // Writes reach the selected link's fields only
    if (bus_req.wr) begin
      if (bus_req.addr == LINK_PAGE_ADDR) begin
        state_next.link_page = bus_req.wdata[BIT_LINK_PAGE];
      end else if (is_prog(bus_req.addr)) begin
        state_next.prog[pg][prog_idx(bus_req.addr)] = bus_req.wdata;
      end else if (bus_req.addr == IRQ_ENABLE_A_ADDR) begin
        state_next.en_a[pg] = bus_req.wdata;
      end else if (bus_req.addr == IRQ_ENABLE_B_ADDR) begin
        state_next.en_b[pg] = bus_req.wdata[BIT_CONFIG_MISM];
      end
    end

    // Reads answer one cycle later; unmapped addresses read zero
    if (bus_req.rd) begin
      if (bus_req.addr == LINK_PAGE_ADDR) begin
        state_next.rdata = {7'h00, state_reg.link_page};
      end else if (is_prog(bus_req.addr)) begin
        state_next.rdata = state_reg.prog[pg][prog_idx(bus_req.addr)];
      end else if (bus_req.addr == LANE7_STATUS_ADDR) begin
        state_next.rdata = {4'h0,
                            flags[pg][BIT_INITIAL_SYNC],
                            flags[pg][BIT_CHECKSUM],
                            flags[pg][BIT_FRAME_SYNC],
                            flags[pg][BIT_CODE_GROUP]};
      end else if (bus_req.addr == IRQ_ENABLE_A_ADDR) begin
        state_next.rdata = state_reg.en_a[pg];
      end else if (bus_req.addr == IRQ_ENABLE_B_ADDR) begin
        state_next.rdata = {7'h00, state_reg.en_b[pg]};
      end else if (bus_req.addr == IRQ_STATUS_A_ADDR) begin
        state_next.rdata = state_reg.st_a[pg];
      end else if (bus_req.addr == IRQ_STATUS_B_ADDR) begin
        state_next.rdata = {7'h00, state_reg.st_b[pg]};
      end
    end
  end

  // State register with documented reset values
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg           <= '0;
      state_reg.link_page <= LINK_PAGE_RESET;
      state_reg.en_a      <= {NUM_LINKS{IRQ_ENABLE_A_RESET}};
      state_reg.en_b      <= {NUM_LINKS{IRQ_ENABLE_B_RESET}};
      state_reg.st_a      <= {NUM_LINKS{IRQ_STATUS_A_RESET}};
      state_reg.st_b      <= {NUM_LINKS{IRQ_STATUS_B_RESET}};
      state_reg.prog      <= {(NUM_LINKS * ILAS_BYTES){ILAS_PROG_RESET}};
      state_reg.prev      <= {NUM_LINKS{LANE7_STATUS_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rdata;

  // Request level: any link, any set status bit with its enable
  always_comb begin
    irq = 1'b0;
    for (int i = 0; i < NUM_LINKS; i++) begin
      irq = irq | (|(state_reg.st_a[i] & state_reg.en_a[i]))
                | (state_reg.st_b[i] & state_reg.en_b[i]);
    end
  end
endmodule

// File: dv/slsi_irq_ctrl_sva.sv
// Port checks for the lane 7 status and link interrupt enable block.
// Assumes lane flags hold still between changes and alignment bytes come in order.
module slsi_irq_ctrl_sva (
  input wire logic                                                   clk,
  input wire logic                                                   reset,
  input wire slsi_pkg::slsi_bus_req_type                              bus_req,
  input wire logic      [7:0]                                        rd_data,
  input wire slsi_pkg::slsi_lane_flags_type [slsi_pkg::NUM_LINKS-1:0] lane_flags_async,
  input wire slsi_pkg::slsi_ilas_byte_type                            ilas_byte,
  input wire logic                                                   irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import slsi_pkg::*;
  logic                                page_reg;
  logic [NUM_LINKS-1:0][7:0]           en_a_reg;
  logic [NUM_LINKS-1:0]                en_b_reg;
  logic [2:0]                          stable_reg;
  logic [7:0]                          sum_reg;
  slsi_lane_flags_type [NUM_LINKS-1:0] flags_prev_reg;
  slsi_lane_flags_type                 sel_flags;
  assign sel_flags = lane_flags_async[page_reg];
  // Shadow page and enables, count quiet cycles of the flags, sum bytes 0..12
  always_ff @(posedge clk) begin
    flags_prev_reg <= lane_flags_async;
    if (ilas_byte.valid)
      sum_reg <= (ilas_byte.idx == 4'h0) ? ilas_byte.data : sum_reg + ilas_byte.data;
    if (reset) begin
      page_reg   <= 1'b0;
      en_a_reg   <= '0;
      en_b_reg   <= '0;
      stable_reg <= 3'h0;
    end else begin
      if (lane_flags_async != flags_prev_reg)
        stable_reg <= 3'h0;
      else if (stable_reg != 3'h7)
        stable_reg <= stable_reg + 3'h1;
      if (bus_req.wr && bus_req.addr == LINK_PAGE_ADDR)
        page_reg <= bus_req.wdata[0];
      if (bus_req.wr && bus_req.addr == IRQ_ENABLE_A_ADDR)
        en_a_reg[page_reg] <= bus_req.wdata;
      if (bus_req.wr && bus_req.addr == IRQ_ENABLE_B_ADDR)
        en_b_reg[page_reg] <= bus_req.wdata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd(logic [11:0] a);
    $past(bus_req.rd) && $past(bus_req.addr) == a;
  endsequence
  sequence s_lane7_rd;
    $past(bus_req.rd) && $past(bus_req.addr) == LANE7_STATUS_ADDR && $past(stable_reg) == 3'h7;
  endsequence
  sequence s_bad_cks;
    ilas_byte.valid && ilas_byte.idx == ILAS_LAST_IDX && ilas_byte.data != sum_reg
      && en_a_reg[ilas_byte.link][BIT_CHECKSUM];
  endsequence
  property p_l7_init_sync;
    s_lane7_rd |-> rd_data[3] == $past(sel_flags.initial_sync);
  endproperty
  property p_l7_checksum;
    s_lane7_rd |-> rd_data[2] == $past(sel_flags.checksum_ok);
  endproperty
  property p_l7_frame_sync;
    s_lane7_rd |-> rd_data[1] == $past(sel_flags.frame_sync);
  endproperty
  property p_l7_code_group;
    s_lane7_rd |-> rd_data[0] == $past(sel_flags.code_group_sync);
  endproperty
  property p_page;
    s_rd(LINK_PAGE_ADDR) |-> rd_data[0] == $past(page_reg);
  endproperty
  property p_en_a;
    s_rd(IRQ_ENABLE_A_ADDR) |-> rd_data == $past(en_a_reg[page_reg]);
  endproperty
  property p_en_b;
    s_rd(IRQ_ENABLE_B_ADDR) |-> rd_data == {7'h00, $past(en_b_reg[page_reg])};
  endproperty
  property p_gate;
    en_a_reg == '0 && en_b_reg == '0 |-> !irq;
  endproperty
  property p_cks;
    s_bad_cks |-> ##[2:3] irq;
  endproperty
  a_l7_init_sync: assert property (p_l7_init_sync) else $error("lane 7 init sync wrong");
  a_l7_checksum: assert property (p_l7_checksum) else $error("lane 7 checksum wrong");
  a_l7_frame_sync: assert property (p_l7_frame_sync) else $error("lane 7 frame wrong");
  a_l7_code_group: assert property (p_l7_code_group) else $error("lane 7 group wrong");
  a_page: assert property (p_page) else $error("page readback wrong");
  a_en_a: assert property (p_en_a) else $error("enable A readback wrong");
  a_en_b: assert property (p_en_b) else $error("enable B readback wrong");
  a_gate: assert property (p_gate) else $error("request with all enables off");
  a_cks: assert property (p_cks) else $error("bad checksum gave no request");
endmodule
bind slsi_irq_ctrl slsi_irq_ctrl_sva u_sva (.clk(clk), .reset(reset), .bus_req(bus_req),
  .rd_data(rd_data), .lane_flags_async(lane_flags_async), .ilas_byte(ilas_byte), .irq(irq));

// File: dv/slsi_tx_model.sv
// Transmitter-side model: per-link lane flags and lane 0 alignment bytes.
// Assumes the bench calls its tasks; outputs change just after clk rises.
module slsi_tx_model (
  input  wire logic                                              clk,
  output slsi_pkg::slsi_lane_flags_type [slsi_pkg::NUM_LINKS-1:0] flags,
  output slsi_pkg::slsi_ilas_byte_type                            ilas
);
  timeunit 1ns;
  timeprecision 1ps;
  import slsi_pkg::*;
  // Quiet start
  initial begin
    flags = '0;
    ilas = '0;
  end
  task automatic set_flags(input logic lk, input slsi_lane_flags_type f);
    @(posedge clk);
    flags[lk] <= f;
  endtask
  // Fourteen bytes back to back; err offsets the checksum byte
  task automatic send_ilas(input logic lk, input logic [7:0] base, input logic [7:0] err);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < ILAS_BYTES - 1; i++) begin
      @(posedge clk);
      ilas <= '{1'b1, lk, 4'(i), base + 8'(i)};
      sum = sum + base + 8'(i);
    end
    @(posedge clk);
    ilas <= '{1'b1, lk, ILAS_LAST_IDX, sum + err};
    @(posedge clk);
    ilas <= '{1'b0, lk, 4'hf, ~(sum + err)};
  endtask
endmodule

// File: dv/serial_link_lane_status_irq_enable_tb_top.sv
// Self-checking bench for the lane 7 status and link interrupt enable block.
// Assumes the transmitter model drives flags and bytes; bus tasks drive the registers.
module serial_link_lane_status_irq_enable_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import slsi_pkg::*;
  `define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] t=%0t got %h expected %h", $time, got, exp); end end
  logic                                clk = 1'b0;
  logic                                reset = 1'b1;
  slsi_bus_req_type                    bus_req = '0;
  logic [7:0]                          rd_data;
  slsi_lane_flags_type [NUM_LINKS-1:0] lane_flags;
  slsi_ilas_byte_type                  ilas_byte;
  logic                                irq;
  logic [7:0]                          cks;
  int                                  fail_count = 0;
  int                                  checked = 0;
  always #5 clk = ~clk;
  slsi_irq_ctrl dut (.clk(clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .lane_flags_async(lane_flags), .ilas_byte(ilas_byte), .irq(irq));
  slsi_tx_model tx (.clk(clk), .flags(lane_flags), .ilas(ilas_byte));
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    bus_req <= '0;
    #1;
    `CHK(rd_data, exp)
  endtask
  // Bounded wait for the request; a timeout ends the run
  task automatic wait_irq();
    for (int n = 0; n < 10 && irq !== 1'b1; n++)
      @(posedge clk);
    #1;
    `CHK(irq, 1'b1)
    if (irq !== 1'b1)
      print_verdict();
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(IRQ_ENABLE_A_ADDR, IRQ_ENABLE_A_RESET);
    rd(IRQ_ENABLE_B_ADDR, 8'h00);
    rd(LANE7_STATUS_ADDR, LANE7_STATUS_RESET);
    rd(12'h4bc, 8'h00);
    wr(IRQ_ENABLE_A_ADDR, 8'hff);
    wr(IRQ_ENABLE_B_ADDR, 8'hff);
    rd(IRQ_ENABLE_A_ADDR, 8'hff);
    rd(IRQ_ENABLE_B_ADDR, 8'h01);
    wr(LINK_PAGE_ADDR, 8'h01);
    rd(LINK_PAGE_ADDR, 8'h01);
    rd(IRQ_ENABLE_A_ADDR, 8'h00);
    wr(IRQ_ENABLE_A_ADDR, 8'ha5);
    rd(IRQ_ENABLE_A_ADDR, 8'ha5);
    wr(IRQ_ENABLE_A_ADDR, 8'h00);
    wr(LINK_PAGE_ADDR, 8'h00);
    rd(IRQ_ENABLE_A_ADDR, 8'hff);
    wr(IRQ_ENABLE_A_ADDR, 8'h00);
    wr(IRQ_ENABLE_B_ADDR, 8'h00);
    $display("test registers done");
    tx.set_flags(1'b0, 8'h0a);
    tx.set_flags(1'b1, 8'h05);
    repeat (8) @(posedge clk);
    rd(LANE7_STATUS_ADDR, 8'h0a);
    wr(LINK_PAGE_ADDR, 8'h01);
    rd(LANE7_STATUS_ADDR, 8'h05);
    wr(LINK_PAGE_ADDR, 8'h00);
    #1;
    `CHK(irq, 1'b0)
    wr(IRQ_ENABLE_A_ADDR, 8'h02);
    tx.set_flags(1'b0, 8'h08);
    wait_irq();
    rd(IRQ_STATUS_A_ADDR, 8'h02);
    wr(IRQ_STATUS_A_ADDR, 8'h02);
    #1;
    `CHK(irq, 1'b0)
    // Counter flag rising raises the bad disparity event
    wr(IRQ_ENABLE_A_ADDR, 8'h80);
    tx.set_flags(1'b0, 8'h88);
    wait_irq();
    rd(IRQ_STATUS_A_ADDR, 8'h80);
    wr(IRQ_STATUS_A_ADDR, 8'h80);
    $display("test lane flags done");
    wr(IRQ_ENABLE_A_ADDR, 8'h04);
    wr(ILAS_PROG_LAST, 8'h77);
    tx.send_ilas(1'b0, 8'h10, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    tx.send_ilas(1'b0, 8'h10, 8'h01);
    wait_irq();
    wr(IRQ_STATUS_A_ADDR, 8'h04);
    wr(IRQ_ENABLE_A_ADDR, 8'h00);
    $display("test checksum done");
    wr(IRQ_STATUS_B_ADDR, 8'h01);
    wr(IRQ_ENABLE_B_ADDR, 8'h01);
    #1;
    `CHK(irq, 1'b0)
    tx.send_ilas(1'b0, 8'h10, 8'h00);
    wait_irq();
    rd(IRQ_STATUS_B_ADDR, 8'h01);
    cks = 8'h00;
    for (int i = 0; i < ILAS_BYTES - 1; i++) begin
      wr(ILAS_PROG_FIRST + 12'(i), 8'h10 + 8'(i));
      cks = cks + 8'h10 + 8'(i);
    end
    wr(ILAS_PROG_LAST, cks);
    wr(IRQ_STATUS_B_ADDR, 8'h01);
    tx.send_ilas(1'b0, 8'h10, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    $display("test config mismatch done");
    print_verdict();
  end
endmodule
